// ==== logic/mps_pkg.sv ====
`default_nettype none
package mps_pkg;
	// Port count and select line count.
	localparam int unsigned NUM_PORTS   = 8;
	localparam int unsigned NUM_SELECTS = 4;
	// Clock rates and period figures.
	localparam int unsigned SYS_CLK_HZ    = 100000000;
	localparam int unsigned FAST_MAX_HZ   = 30000000;
	localparam int unsigned FAST_MIN_HZ   = 8000;
	localparam int unsigned SLOW_MAX_HZ   = 2066000;
	localparam int unsigned SLOW_MIN_HZ   = 485000;
	localparam int unsigned GAP_MAX_US    = 1000;
	localparam int unsigned LINK_CLK_HZ   = 83333333;
	// Half period bounds in link cycles; least times round up.
	localparam int unsigned FAST_HALF_MIN =
		(LINK_CLK_HZ + 2 * FAST_MAX_HZ - 1) / (2 * FAST_MAX_HZ);
	localparam int unsigned FAST_HALF_MAX = LINK_CLK_HZ / (2 * FAST_MIN_HZ);
	localparam int unsigned SLOW_HALF_MIN =
		(LINK_CLK_HZ + 2 * SLOW_MAX_HZ - 1) / (2 * SLOW_MAX_HZ);
	localparam int unsigned SLOW_HALF_MAX = LINK_CLK_HZ / (2 * SLOW_MIN_HZ);
	localparam int unsigned GAP_MAX_CYC   =
		GAP_MAX_US * (LINK_CLK_HZ / 1000000);
	localparam int unsigned HALF_W = 16;
	localparam int unsigned GAP_W  = 17;
	localparam logic [HALF_W-1:0] HALF_MIN_FAST = HALF_W'(FAST_HALF_MIN);
	localparam logic [HALF_W-1:0] HALF_MAX_FAST = HALF_W'(FAST_HALF_MAX);
	localparam logic [HALF_W-1:0] HALF_MIN_SLOW = HALF_W'(SLOW_HALF_MIN);
	localparam logic [HALF_W-1:0] HALF_MAX_SLOW = HALF_W'(SLOW_HALF_MAX);
	localparam logic [GAP_W-1:0]  GAP_LIMIT     = GAP_W'(GAP_MAX_CYC);
	// Bit counter limits.
	localparam logic [2:0] BIT_LAST  = 3'h7;
	localparam logic [2:0] BIT_FIRST = 3'h0;

	// Transfer configuration, held stable while busy.
	typedef struct packed {
		logic [2:0]        port;
		logic              cpol;
		logic              cpha;
		logic              lsb_first;
		logic [HALF_W-1:0] half_period;
		logic [GAP_W-1:0]  gap_cycles;
	} mps_cfg_t;

	// Link state machine.
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_LOAD  = 3'b001,
		ST_LEAD  = 3'b010,
		ST_TRAIL = 3'b011,
		ST_GAP   = 3'b100,
		ST_DONE  = 3'b101
	} mps_state_t;
endpackage : mps_pkg
`default_nettype wire

// ==== logic/mps_spi_master.sv ====
`default_nettype none

// Small synchronous FIFO between the host domain and the link domain words.
module mps_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	// Clock and reset.
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	// Fill side.
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side.
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int unsigned AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin
			$error("FIFO depth must be a power of two");
		end
	end
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
	logic             push, pop;

	// Pointer arithmetic.
	always_comb begin
		push = in_valid_i && in_ready_o;
		pop  = out_valid_o && out_ready_i;
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
	end

	// Storage and pointers.
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data_i;
		end
	end

	// Status flags.
	always_comb begin
		in_ready_o  = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
		out_valid_o = wr_q != rd_q;
		out_data_o  = mem_q[rd_q[AW-1:0]];
	end
endmodule : mps_fifo

module mps_spi_master
	import mps_pkg::*;
#(
	parameter int unsigned DEPTH = 4
) (
	// Host domain clock and reset.
	input  wire logic             clk_sys_i,
	input  wire logic             reset_n_i,
	// Link clock domain.
	input  wire logic             clk_link_i,
	// Host configuration and control.
	input  wire mps_cfg_t         cfg_i,
	input  wire logic             start_i,
	input  wire logic             two_wire_i,
	input  wire logic             select_three_reset_i,
	input  wire logic             processor_reset_i,
	// Host byte streams.
	input  wire logic             tx_valid_i,
	output logic                  tx_ready_o,
	input  wire logic       [7:0] tx_data_i,
	output logic                  rx_valid_o,
	output logic            [7:0] rx_data_o,
	output logic                  busy_o,
	output logic                  cfg_error_o,
	// Target pins.
	output logic                  sclk_o,
	output logic                  sclk_oe_o,
	output logic                  mosi_o,
	output logic                  mosi_oe_o,
	input  wire logic             miso_i,
	output logic                  select_line_zero_o,
	output logic                  select_line_one_o,
	output logic                  select_line_two_o,
	output logic                  select_line_three_o,
	output logic      [NUM_SELECTS-1:0] select_oe_o
);
	initial begin
		if (DEPTH != 4) begin
			$error("Transfer FIFO depth must be four");
		end
	end

	// Configuration check in the host domain.
	logic cfg_ok;
	always_comb begin
		if (cfg_i.port[0] == 1'b0) begin
			cfg_ok = !cfg_i.cpha && cfg_i.half_period >= HALF_MIN_FAST
				&& cfg_i.half_period <= HALF_MAX_FAST;
		end else begin
			cfg_ok = cfg_i.half_period >= HALF_MIN_SLOW
				&& cfg_i.half_period <= HALF_MAX_SLOW;
		end
		if (cfg_i.gap_cycles > GAP_LIMIT) begin
			cfg_ok = 1'b0;
		end
		if (select_three_reset_i && cfg_i.port[2:1] == 2'h3) begin
			cfg_ok = 1'b0;
		end
	end

	// Start toggle, busy tracking and error flag.
	logic go_tgl_q, go_tgl_d, busy_q, busy_d, err_q, err_d;
	logic done_s1_q, done_s2_q, done_s3_q;
	logic done_tgl_q;
	always_comb begin
		go_tgl_d = go_tgl_q;
		busy_d   = busy_q;
		err_d    = err_q;
		if (done_s3_q != done_s2_q) begin
			busy_d = 1'b0;
		end
		if (start_i && !busy_q) begin
			if (cfg_ok) begin
				go_tgl_d = ~go_tgl_q;
				busy_d   = 1'b1;
				err_d    = 1'b0;
			end else begin
				err_d = 1'b1;
			end
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			go_tgl_q  <= 1'b0;
			busy_q    <= 1'b0;
			err_q     <= 1'b0;
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
			done_s3_q <= 1'b0;
		end else begin
			go_tgl_q  <= go_tgl_d;
			busy_q    <= busy_d;
			err_q     <= err_d;
			done_s1_q <= done_tgl_q;
			done_s2_q <= done_s1_q;
			done_s3_q <= done_s2_q;
		end
	end
	assign busy_o      = busy_q;
	assign cfg_error_o = err_q;

	// Host-side FIFO; link side drains it through a word handshake.
	logic       f_valid, f_ready;
	logic [7:0] f_data;
	mps_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
		.clk_i       (clk_sys_i),
		.reset_n_i   (reset_n_i),
		.in_valid_i  (tx_valid_i && busy_q),
		.in_ready_o  (tx_ready_o),
		.in_data_i   (tx_data_i),
		.out_valid_o (f_valid),
		.out_ready_i (f_ready),
		.out_data_o  (f_data)
	);

	// Word handshake: request toggle to link, acknowledge toggle back.
	logic       req_q, req_d, ack_s1_q, ack_s2_q, ack_s3_q, ack_tgl_q;
	logic       sent_q, sent_d, stop_q, stop_d;
	logic [7:0] word_q, word_d;
	always_comb begin
		req_d   = req_q;
		word_d  = word_q;
		sent_d  = sent_q && busy_q;
		f_ready = 1'b0;
		if (req_q == ack_s2_q && f_valid && ack_s3_q == ack_s2_q) begin
			f_ready = 1'b1;
			word_d  = f_data;
			req_d   = ~req_q;
			sent_d  = 1'b1;
		end
		// End of stream: a byte went out, the queue is dry and acknowledged.
		stop_d = busy_q && sent_q && !tx_valid_i && !f_valid
			&& req_q == ack_s3_q && ack_s3_q == ack_s2_q;
	end
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			req_q    <= 1'b0;
			sent_q   <= 1'b0;
			stop_q   <= 1'b0;
			word_q   <= 8'h00;
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
			ack_s3_q <= 1'b0;
		end else begin
			req_q    <= req_d;
			sent_q   <= sent_d;
			stop_q   <= stop_d;
			word_q   <= word_d;
			ack_s1_q <= ack_tgl_q;
			ack_s2_q <= ack_s1_q;
			ack_s3_q <= ack_s2_q;
		end
	end

	// Received byte toggle into the host domain.
	logic       rxt_tgl_q, rxt_s1_q, rxt_s2_q, rxt_s3_q;
	logic [7:0] rx_link_q, rx_q;
	logic       rxv_q;
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			rxt_s1_q <= 1'b0;
			rxt_s2_q <= 1'b0;
			rxt_s3_q <= 1'b0;
			rxv_q    <= 1'b0;
			rx_q     <= 8'h00;
		end else begin
			rxt_s1_q <= rxt_tgl_q;
			rxt_s2_q <= rxt_s1_q;
			rxt_s3_q <= rxt_s2_q;
			rxv_q    <= rxt_s3_q != rxt_s2_q;
			if (rxt_s3_q != rxt_s2_q) begin
				rx_q <= rx_link_q;
			end
		end
	end
	assign rx_valid_o = rxv_q;
	assign rx_data_o  = rx_q;

	// Link domain: reset and control synchronisers.
	logic lrst_s1_q, lrst_n_q;
	logic go_s1_q, go_s2_q, go_s3_q, req_s1_q, req_s2_q;
	logic stop_s1_q, stop_s2_q;
	logic miso_s1_q, miso_s2_q, srst_s1_q, srst_s2_q;
	always_ff @(posedge clk_link_i) begin
		lrst_s1_q <= reset_n_i;
		lrst_n_q  <= lrst_s1_q;
		go_s1_q   <= go_tgl_q;
		go_s2_q   <= go_s1_q;
		go_s3_q   <= go_s2_q;
		req_s1_q  <= req_q;
		req_s2_q  <= req_s1_q;
		stop_s1_q <= stop_q;
		stop_s2_q <= stop_s1_q;
		miso_s1_q <= miso_i;
		miso_s2_q <= miso_s1_q;
		srst_s1_q <= processor_reset_i;
		srst_s2_q <= srst_s1_q;
	end

	// Link state machine.
	mps_state_t        st_q, st_d;
	logic [HALF_W-1:0] cnt_q, cnt_d;
	logic [GAP_W-1:0]  gap_q, gap_d;
	logic [2:0]        bit_q, bit_d;
	logic [7:0]        sh_q, sh_d, in_q, in_d;
	logic              sck_q, sck_d, mo_q, mo_d, act_q, act_d;
	logic              done_d, ack_d, rxt_d, miso_bit;
	logic [7:0]        rxl_d;
	mps_cfg_t          lcfg;
	assign lcfg = cfg_i;
	assign miso_bit = two_wire_i ? miso_s2_q : miso_s2_q;
	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		gap_d  = gap_q;
		bit_d  = bit_q;
		sh_d   = sh_q;
		in_d   = in_q;
		sck_d  = sck_q;
		mo_d   = mo_q;
		act_d  = act_q;
		done_d = done_tgl_q;
		ack_d  = ack_tgl_q;
		rxt_d  = rxt_tgl_q;
		rxl_d  = rx_link_q;
		case (st_q)
			ST_IDLE: begin
				sck_d = lcfg.cpol;
				act_d = 1'b0;
				if (go_s3_q != go_s2_q) begin
					act_d = 1'b1;
					st_d  = ST_LOAD;
				end
			end
			ST_LOAD: begin
				// A pending word is a level, so it is not lost while shifting.
				if (req_s2_q != ack_tgl_q) begin
					ack_d = ~ack_tgl_q;
					sh_d  = lcfg.lsb_first ? {<<{word_q}} : word_q;
					mo_d  = lcfg.lsb_first ? word_q[0] : word_q[7];
					bit_d = BIT_FIRST;
					cnt_d = lcfg.half_period;
					st_d  = ST_LEAD;
				end else if (stop_s2_q) begin
					st_d = ST_DONE;
				end
			end
			ST_LEAD: begin
				cnt_d = cnt_q - 1'b1;
				if (cnt_q == HALF_W'(1)) begin
					cnt_d = lcfg.half_period;
					sck_d = ~sck_q;
					if (!lcfg.cpha) begin
						in_d = {in_q[6:0], miso_bit};
					end else begin
						mo_d = sh_q[7];
					end
					st_d = ST_TRAIL;
				end
			end
			ST_TRAIL: begin
				cnt_d = cnt_q - 1'b1;
				if (cnt_q == HALF_W'(1)) begin
					cnt_d = lcfg.half_period;
					sck_d = ~sck_q;
					sh_d  = {sh_q[6:0], 1'b0};
					if (lcfg.cpha) begin
						in_d = {in_q[6:0], miso_bit};
					end else begin
						mo_d = sh_q[6];
					end
					bit_d = bit_q + 1'b1;
					st_d  = ST_LEAD;
					if (bit_q == BIT_LAST) begin
						rxt_d = ~rxt_tgl_q;
						rxl_d = lcfg.lsb_first ? {<<{in_d}} : in_d;
						gap_d = lcfg.gap_cycles;
						st_d  = ST_GAP;
					end
				end
			end
			ST_GAP: begin
				if (gap_q == '0) begin
					st_d = ST_LOAD;
				end else begin
					gap_d = gap_q - 1'b1;
				end
			end
			ST_DONE: begin
				done_d = ~done_tgl_q;
				act_d  = 1'b0;
				st_d   = ST_IDLE;
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk_link_i) begin
		if (!lrst_n_q) begin
			st_q       <= ST_IDLE;
			cnt_q      <= '0;
			gap_q      <= '0;
			bit_q      <= BIT_FIRST;
			sh_q       <= 8'h00;
			in_q       <= 8'h00;
			sck_q      <= 1'b0;
			mo_q       <= 1'b0;
			act_q      <= 1'b0;
			done_tgl_q <= 1'b0;
			ack_tgl_q  <= 1'b0;
			rxt_tgl_q  <= 1'b0;
			rx_link_q  <= 8'h00;
		end else begin
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			gap_q      <= gap_d;
			bit_q      <= bit_d;
			sh_q       <= sh_d;
			in_q       <= in_d;
			sck_q      <= sck_d;
			mo_q       <= mo_d;
			act_q      <= act_d;
			done_tgl_q <= done_d;
			ack_tgl_q  <= ack_d;
			rxt_tgl_q  <= rxt_d;
			rx_link_q  <= rxl_d;
		end
	end

	// Pin registers; float when idle except select line three during processor reset, pair select decode.
	logic [NUM_SELECTS-1:0] sel_q, oe_q;
	logic                   pin_oe_q, sck_pin_q, mo_pin_q;
	always_ff @(posedge clk_link_i) begin
		if (!lrst_n_q) begin
			sel_q     <= '1;
			oe_q      <= '0;
			pin_oe_q  <= 1'b0;
			sck_pin_q <= 1'b0;
			mo_pin_q  <= 1'b0;
		end else begin
			sel_q     <= '1;
			oe_q      <= '0;
			pin_oe_q  <= act_q;
			sck_pin_q <= sck_q;
			mo_pin_q  <= mo_q;
			if (act_q) begin
				sel_q[lcfg.port[2:1]] <= 1'b0;
				oe_q[lcfg.port[2:1]]  <= 1'b1;
			end
			if (select_three_reset_i) begin
				sel_q[NUM_SELECTS-1] <= ~srst_s2_q;
				oe_q[NUM_SELECTS-1]  <= srst_s2_q;
			end
		end
	end
	assign sclk_o              = sck_pin_q;
	assign sclk_oe_o           = pin_oe_q;
	assign mosi_o              = mo_pin_q;
	assign mosi_oe_o           = pin_oe_q && !two_wire_i;
	assign select_line_zero_o  = sel_q[0];
	assign select_line_one_o   = sel_q[1];
	assign select_line_two_o   = sel_q[2];
	assign select_line_three_o = sel_q[3];
	assign select_oe_o         = oe_q;

	// Checks on the link and on the host-domain start and configuration.
	property p_float_idle;
		@(posedge clk_link_i) disable iff (!lrst_n_q)
		(st_q == ST_IDLE && $past(st_q) == ST_IDLE) |=> !sclk_oe_o;
	endproperty
	a_float_idle: assert property (p_float_idle)
		else $error("Pins driven while idle");
	property p_sel_gap;
		@(posedge clk_link_i) disable iff (!lrst_n_q)
		(st_q == ST_GAP) |=> (sel_q[lcfg.port[2:1]] == 1'b0);
	endproperty
	a_sel_gap: assert property (p_sel_gap)
		else $error("Select released during gap");
	sequence s_lead_edge;
		st_q == ST_LEAD && cnt_q == HALF_W'(1);
	endsequence
	property p_edge_toggle;
		@(posedge clk_link_i) disable iff (!lrst_n_q)
		s_lead_edge |=> (sck_q != $past(sck_q)) && st_q == ST_TRAIL;
	endproperty
	a_edge_toggle: assert property (p_edge_toggle)
		else $error("Clock did not toggle at half period");
	property p_one_sel;
		@(posedge clk_link_i) disable iff (!lrst_n_q)
		$onehot0(~sel_q[2:0]);
	endproperty
	a_one_sel: assert property (p_one_sel)
		else $error("More than one select low");
	property p_bad_cfg;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		(start_i && !busy_q && !cfg_ok) |=> cfg_error_o && !busy_o;
	endproperty
	a_bad_cfg: assert property (p_bad_cfg)
		else $error("Bad configuration accepted");
	property p_fast_cpha;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		(start_i && !busy_q && !cfg_i.port[0] && cfg_i.cpha) |=> !busy_o;
	endproperty
	a_fast_cpha: assert property (p_fast_cpha)
		else $error("Even port ran clock phase one");
	property p_rate;
		@(posedge clk_link_i) disable iff (!lrst_n_q)
		(st_q == ST_LOAD && st_d == ST_LEAD) |=> cnt_q == lcfg.half_period;
	endproperty
	a_rate: assert property (p_rate)
		else $error("Half period not loaded");
	property p_reserved;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		(start_i && !busy_q && select_three_reset_i
			&& cfg_i.port[2:1] == 2'h3) |=> cfg_error_o;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("Reserved port accepted");
endmodule : mps_spi_master
`default_nettype wire

// ==== sim/mps_target.sv ====
`default_nettype none
// Behavioural SPI target: sends the same reply byte for every byte, logs each byte on mosi.
module mps_target
	import mps_pkg::*;
(
	// Board pins.
	input  wire logic       sclk_i,
	input  wire logic       mosi_i,
	input  wire logic       sel_n_i,
	// Mode and reply.
	input  wire mps_cfg_t   cfg_i,
	input  wire logic [7:0] reply_i,
	// Data line and log.
	output var logic        miso_o,
	output var logic        stb_o,
	output var logic  [7:0] byte_o,
	output var int          frames_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int         n;
	logic       up;
	logic [7:0] sh;
	// Reply bit i in the chosen order.
	function automatic logic bit_of(input int i);
		return reply_i[cfg_i.lsb_first ? i : 7 - i];
	endfunction : bit_of
	// Quiet start.
	initial begin
		miso_o = 1'b0;
		stb_o = 1'b0;
		byte_o = 8'h00;
		frames_o = 0;
	end
	// Frame start: count it, present bit 0 for phase 0.
	always @(negedge sel_n_i) begin
		frames_o++;
		n = 0;
		up = 1'b0;
		if (!cfg_i.cpha) miso_o = bit_of(0);
	end
	// A released line shows the inverse of its last level.
	always @(posedge sel_n_i) miso_o = ~miso_o;
	always @(sclk_i) begin
		if (sel_n_i === 1'b0) begin
			// Ignore the settle of the pin before the first leading edge.
			if (sclk_i != cfg_i.cpol) up = 1'b1;
			if (up && ((sclk_i != cfg_i.cpol) == !cfg_i.cpha)) begin
				sh[cfg_i.lsb_first ? n : 7 - n] = mosi_i;
				n = (n + 1) % 8;
				if (n == 0) begin
					byte_o = sh;
					stb_o = 1'b1;
					#1 stb_o = 1'b0;
				end
			end else if (up) begin
				miso_o = bit_of(n);
			end
		end
	end
endmodule : mps_target
`default_nettype wire

// ==== sim/tb.sv ====
`default_nettype none
// Bench: drives the host side, checks both byte streams and the pins.
module tb
	import mps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_sys_i, clk_link_i, reset_n_i, start, two_wire, sel3_rst;
	logic       proc_rst, tx_valid, tx_ready, rx_valid, busy, cfg_err;
	logic       sclk, sclk_oe, mosi, mosi_oe, miso, tgt_stb, sclk_w, mosi_w;
	logic [7:0] tx_data, rx_data, reply, tgt_byte;
	logic [3:0] sel_oe, pin;
	wire  [3:0] sel;
	mps_cfg_t   cfg;
	int         frames, seed, fails = 0, total_checks = 0;
	logic       full_seen = 1'b0;
	realtime    t_last = 0.0, t_half;
	logic [7:0] rx_q[$], tx_q[$];
	int         bad_hp[8] = '{2, SLOW_HALF_MIN - 1, FAST_HALF_MIN - 1,
		SLOW_HALF_MAX + 1, FAST_HALF_MAX + 1, 21, 2, 21};
	// Pull-ups hold every released line high.
	assign pin    = (sel & sel_oe) | ~sel_oe;
	assign sclk_w = sclk_oe ? sclk : 1'b1;
	assign mosi_w = mosi_oe ? mosi : 1'b1;
	mps_spi_master #(.DEPTH(4)) mps_spi_master_i (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clk_link_i(clk_link_i),
		.cfg_i(cfg), .start_i(start), .two_wire_i(two_wire),
		.select_three_reset_i(sel3_rst), .processor_reset_i(proc_rst),
		.tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .tx_data_i(tx_data),
		.rx_valid_o(rx_valid), .rx_data_o(rx_data), .busy_o(busy),
		.cfg_error_o(cfg_err), .sclk_o(sclk), .sclk_oe_o(sclk_oe),
		.mosi_o(mosi), .mosi_oe_o(mosi_oe), .miso_i(miso),
		.select_line_zero_o(sel[0]), .select_line_one_o(sel[1]),
		.select_line_two_o(sel[2]), .select_line_three_o(sel[3]),
		.select_oe_o(sel_oe));
	mps_target mps_target_i (.sclk_i(sclk_w), .mosi_i(mosi_w),
		.sel_n_i(pin[cfg.port[2:1]]), .cfg_i(cfg), .reply_i(reply),
		.miso_o(miso), .stb_o(tgt_stb), .byte_o(tgt_byte), .frames_o(frames));
	// System clock, 10 ns.
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// Link clock, 12 ns, offset in phase.
	initial begin
		clk_link_i = 1'b0;
		#3.3;
		forever #6 clk_link_i = ~clk_link_i;
	end
	// Time between the last two edges on the clock pin.
	always @(sclk_w) begin
		t_half = $realtime - t_last;
		t_last = $realtime;
	end
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (e !== g) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	// Received bytes against the replies noted at push time.
	always @(posedge clk_sys_i) begin
		if (rx_valid === 1'b1) begin
			if (rx_q.size() == 0) chk("rx count", 0, 1);
			else chk("rx byte", 32'(rx_q.pop_front()), 32'(rx_data));
		end
	end
	// Bytes seen by the target, with selects and clock rate at that time.
	always @(posedge tgt_stb) begin
		if (tx_q.size() == 0) chk("tx count", 0, 1);
		else chk("tx byte", 32'(tx_q.pop_front()), 32'(tgt_byte));
		chk("selects", 32'(4'(~(4'h1 << cfg.port[2:1]))), 32'(pin));
		chk("half", 32'(cfg.half_period) * 12, int'(t_half));
	end
	// The data-out pin stays undriven in two-wire mode.
	always @(posedge clk_link_i) begin
		if (two_wire === 1'b1 && mosi_oe !== 1'b0) chk("mosi oe", 0, 1);
	end
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	task automatic timeout(input string what);
		fails++;
		$display("BAD %s expected done seen timeout", what);
		conclude();
	endtask : timeout
	task automatic go(input mps_cfg_t c, input logic ok);
		@(posedge clk_sys_i);
		cfg <= c;
		start <= 1'b1;
		@(posedge clk_sys_i);
		start <= 1'b0;
		@(negedge clk_sys_i);
		chk("busy", 32'(ok), 32'(busy));
		chk("cfg error", 32'(!ok), 32'(cfg_err));
		@(posedge clk_sys_i);
	endtask : go
	task automatic push(input logic [7:0] b);
		int k;
		k = 0;
		tx_valid <= 1'b1;
		tx_data <= b;
		tx_q.push_back(two_wire ? 8'hff : b);
		rx_q.push_back(reply);
		@(negedge clk_sys_i);
		while (tx_ready !== 1'b1 && k < 9000) begin
			full_seen = 1'b1;
			@(negedge clk_sys_i);
			k++;
		end
		if (k == 9000) timeout("tx ready");
		@(posedge clk_sys_i);
	endtask : push
	task automatic xfer(input int p, m, nb, hp, gp);
		mps_cfg_t c;
		int       k;
		int       f0;
		c = '{port: 3'(p), cpol: m[1], cpha: m[0], lsb_first: 1'($random(seed)),
			half_period: HALF_W'(hp), gap_cycles: GAP_W'(gp)};
		reply <= 8'($random(seed));
		f0 = frames;
		go(c, 1'b1);
		for (int i = 0; i < nb; i++) push(8'($random(seed)));
		tx_valid <= 1'b0;
		k = 0;
		while (busy !== 1'b0 && k < 60000) begin
			@(negedge clk_sys_i);
			k++;
		end
		if (k == 60000) timeout("busy");
		@(posedge clk_sys_i);
		chk("frames", 32'(f0 + 1), 32'(frames));
		chk("drive", 0, 32'({sclk_oe, mosi_oe, sel_oe}));
		chk("pins", 32'hf, 32'(pin));
		$display("test port %0d mode %0d done", p, m);
	endtask : xfer
	// Main sequence.
	initial begin
		seed = 26;
		reset_n_i = 1'b0;
		start = 1'b0;
		two_wire = 1'b0;
		sel3_rst = 1'b0;
		proc_rst = 1'b0;
		tx_valid = 1'b0;
		tx_data = 8'h00;
		reply = 8'h00;
		cfg = '0;
		repeat (12) @(posedge clk_sys_i);
		chk("reset", 0, 32'({sclk_oe, mosi_oe, sel_oe, busy}));
		reset_n_i <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		for (int p = 0; p < 8; p++) begin
			for (int m = 0; m < 4; m++) begin
				if (p % 2 == 1) xfer(p, m, 2, m > 1 ? SLOW_HALF_MAX : SLOW_HALF_MIN, 0);
				// Synced data-in needs three link cycles of round trip.
				else if (m % 2 == 0) xfer(p, m, 2, FAST_HALF_MIN + 2, 0);
			end
		end
		xfer(3, 1, 7, SLOW_HALF_MAX, 40);
		chk("fifo full", 1, 32'(full_seen));
		for (int i = 0; i < 8; i++) begin
			sel3_rst <= (i > 5);
			go('{port: 3'(i), cpol: 1'b0, cpha: (i == 0), lsb_first: 1'b0,
				half_period: HALF_W'(bad_hp[i]),
				gap_cycles: GAP_W'(i == 5 ? GAP_MAX_CYC + 1 : 0)}, 1'b0);
		end
		$display("test refusals done");
		sel3_rst <= 1'b0;
		two_wire <= 1'b1;
		xfer(4, 2, 2, FAST_HALF_MIN + 2, 0);
		two_wire <= 1'b0;
		sel3_rst <= 1'b1;
		proc_rst <= 1'b1;
		repeat (12) @(posedge clk_sys_i);
		chk("reset line", 0, 32'(pin[3]));
		proc_rst <= 1'b0;
		repeat (12) @(posedge clk_sys_i);
		chk("reset line", 1, 32'(pin[3]));
		$display("test processor reset done");
		chk("left", 0, 32'(rx_q.size() + tx_q.size()));
		conclude();
	end
endmodule : tb
`default_nettype wire
